// >>> design/wkt_prescaler.v
// Counter clock source selection and cascaded prescalers producing a count enable.
`include "wkt_regs.vh"

module wkt_prescaler (
	// Clock and power-up reset
	input wire hclk,
	input wire por_n,
	// Oscillator pins, unrelated to hclk
	input wire slow_internal_oscillator,
	input wire slow_crystal_oscillator,
	input wire fast_internal_oscillator,
	// Configuration
	input wire run,
	input wire [1:0] clk_sel,
	input wire prescale_by_512_enable,
	input wire prescale_by_32_enable,
	// One-cycle counter increment enable
	output reg tick_r
);

	reg [2:0] osc_s1_r;
	reg [2:0] osc_s2_r;
	reg [2:0] osc_prev_r;
	reg [`WKT_DIVA_W-1:0] diva_r;
	reg [`WKT_DIVB_W-1:0] divb_r;
	reg src_tick;
	wire [2:0] osc_rise;
	wire diva_out;
	wire divb_out;

	// Oscillators are sampled at 250 MHz; the fastest source is 16 MHz, so every edge is seen.
	always @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			osc_s1_r <= 3'h0;
			osc_s2_r <= 3'h0;
			osc_prev_r <= 3'h0;
		end else begin
			osc_s1_r <= {fast_internal_oscillator, slow_crystal_oscillator,
				slow_internal_oscillator};
			osc_s2_r <= osc_s1_r;
			osc_prev_r <= osc_s2_r;
		end
	end

	assign osc_rise = osc_s2_r & ~osc_prev_r;

	always @* begin
		case (clk_sel)
			`WKT_SEL_SLOW_INT: src_tick = osc_rise[0];
			`WKT_SEL_SLOW_XTAL: src_tick = osc_rise[1];
			`WKT_SEL_FAST_INT: src_tick = osc_rise[2];
			default: src_tick = 1'b0;
		endcase
	end

	assign diva_out = prescale_by_512_enable ? (src_tick && diva_r == `WKT_DIVA_LAST) : src_tick;
	assign divb_out = prescale_by_32_enable ? (diva_out && divb_r == `WKT_DIVB_LAST) : diva_out;

	always @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			diva_r <= {`WKT_DIVA_W{1'b0}};
			divb_r <= {`WKT_DIVB_W{1'b0}};
			tick_r <= 1'b0;
		end else begin
			if (src_tick && prescale_by_512_enable)
				diva_r <= diva_r + 1'b1;
			if (diva_out && prescale_by_32_enable)
				divb_r <= divb_r + 1'b1;
			tick_r <= run & divb_out;
		end
	end

endmodule

// >>> design/wkt_top.v
// Wake-up timer with periodic and long-interval compares and wake-up event flags.
`include "wkt_regs.vh"

module wkt_top #(
	parameter NSRC = 29
) (
	// Clock and resets
	input wire hclk,
	input wire hresetn,
	input wire por_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Counter clock sources
	input wire slow_internal_oscillator,
	input wire slow_crystal_oscillator,
	input wire fast_internal_oscillator,
	// External wake-up pins
	input wire [NSRC-`WKT_SRC_INT_N-1:0] wake_pin,
	// Mode controller side
	input wire lp_mode,
	output reg wakeup_req_r,
	output reg irq_r,
	// Timer match pulses
	output reg pit_match_r,
	output reg lit_match_r
);

	// Bus state.
	reg wr_pend_r;
	reg [`WKT_ADDR_W-1:0] wr_addr_r;
	reg rd_wait_r;
	reg [`WKT_ADDR_W-1:0] rd_addr_r;
	wire addr_take;

	// Software registers.
	reg [NSRC-1:0] wakeup_status_flags;
	reg [NSRC-1:0] rise_edge_event_enables;
	reg [NSRC-1:0] fall_edge_event_enables;
	reg [NSRC-1:0] flag_irq_enables;
	reg [`WKT_CTRL_W-1:0] ctrl_r;
	reg [`WKT_PIT_W-1:0] pit_interval_r;
	reg [`WKT_PIT_W-1:0] pit_cmp_r;
	reg [`WKT_LIT_W-1:0] lit_cmp_r;

	// Counter and events.
	reg [`WKT_CNT_W-1:0] cnt_r;
	wire [`WKT_CNT_W-1:0] cnt_inc;
	wire tick;
	wire pit_hit;
	wire lit_hit;
	reg [NSRC-`WKT_SRC_INT_N-1:0] pin_s1_r;
	reg [NSRC-`WKT_SRC_INT_N-1:0] pin_s2_r;
	reg [NSRC-1:0] src_prev_r;
	wire [NSRC-1:0] src_lvl;
	wire [NSRC-1:0] src_event;
	wire [NSRC-1:0] clr_mask;
	wire [NSRC-1:0] flags_nxt;
	reg [31:0] rd_mux;

	wire wr_ctrl;
	wire wr_pit;
	wire wr_lit;

	wkt_prescaler u_prescaler (
		.hclk(hclk),
		.por_n(por_n),
		.slow_internal_oscillator(slow_internal_oscillator),
		.slow_crystal_oscillator(slow_crystal_oscillator),
		.fast_internal_oscillator(fast_internal_oscillator),
		.run(ctrl_r[`WKT_CTRL_RUN]),
		.clk_sel(ctrl_r[`WKT_CTRL_SEL_MSB:`WKT_CTRL_SEL_LSB]),
		.prescale_by_512_enable(ctrl_r[`WKT_CTRL_PRESCALE_BY_512_ENABLE]),
		.prescale_by_32_enable(ctrl_r[`WKT_CTRL_DIV32]),
		.tick_r(tick)
	);

	// Bus slave. Writes finish with no wait; reads take one wait state so that the
	// read data always reflect a write that ended in the preceding cycle.
	assign addr_take = hsel & hready & htrans[1];
	assign hreadyout = ~rd_wait_r;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= {`WKT_ADDR_W{1'b0}};
			rd_wait_r <= 1'b0;
			rd_addr_r <= {`WKT_ADDR_W{1'b0}};
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_r <= addr_take & hwrite;
			rd_wait_r <= addr_take & ~hwrite;
			if (addr_take) begin
				wr_addr_r <= haddr[`WKT_ADDR_W-1:0];
				rd_addr_r <= haddr[`WKT_ADDR_W-1:0];
			end
			if (rd_wait_r)
				hrdata <= rd_mux;
		end
	end

	always @* begin
		case (rd_addr_r)
			`WKT_OFS_STATUS: rd_mux = {{(32-NSRC){1'b0}}, wakeup_status_flags};
			`WKT_OFS_RISE_EN: rd_mux = {{(32-NSRC){1'b0}}, rise_edge_event_enables};
			`WKT_OFS_FALL_EN: rd_mux = {{(32-NSRC){1'b0}}, fall_edge_event_enables};
			`WKT_OFS_IRQ_EN: rd_mux = {{(32-NSRC){1'b0}}, flag_irq_enables};
			`WKT_OFS_CTRL: rd_mux = {{(32-`WKT_CTRL_W){1'b0}}, ctrl_r};
			`WKT_OFS_PIT_INTERVAL: rd_mux = {{(32-`WKT_PIT_W){1'b0}}, pit_interval_r};
			`WKT_OFS_LIT_CMP: rd_mux = {{(32-`WKT_LIT_W){1'b0}}, lit_cmp_r};
			`WKT_OFS_COUNT: rd_mux = cnt_r;
			`WKT_OFS_PIT_CMP: rd_mux = {{(32-`WKT_PIT_W){1'b0}}, pit_cmp_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign wr_ctrl = wr_pend_r && wr_addr_r == `WKT_OFS_CTRL;
	assign wr_pit = wr_pend_r && wr_addr_r == `WKT_OFS_PIT_INTERVAL;
	assign wr_lit = wr_pend_r && wr_addr_r == `WKT_OFS_LIT_CMP;

	// Counter configuration lives on the power-up reset so that a functional reset
	// neither stops the counter nor changes its rate.
	always @(posedge hclk or negedge por_n) begin
		if (!por_n)
			ctrl_r <= `WKT_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= hwdata[`WKT_CTRL_W-1:0];
	end

	assign cnt_inc = cnt_r + 32'h00000001;

	always @(posedge hclk or negedge por_n) begin
		if (!por_n)
			cnt_r <= 32'h00000000;
		else if (tick)
			cnt_r <= cnt_inc;
	end

	assign pit_hit = tick & ctrl_r[`WKT_CTRL_PIT_EN] &
		(cnt_inc[`WKT_PIT_MSB:0] == pit_cmp_r);

	assign lit_hit = tick & ctrl_r[`WKT_CTRL_LIT_EN] &
		(cnt_inc[`WKT_LIT_MSB:`WKT_LIT_LSB] == lit_cmp_r) &
		(cnt_inc[`WKT_PIT_MSB:0] == {`WKT_PIT_W{1'b0}});

	// A write of the interval rearms the compare one interval ahead of now.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pit_interval_r <= {`WKT_PIT_W{1'b0}};
			pit_cmp_r <= {`WKT_PIT_W{1'b0}};
			lit_cmp_r <= {`WKT_LIT_W{1'b0}};
			pit_match_r <= 1'b0;
			lit_match_r <= 1'b0;
		end else begin
			pit_match_r <= pit_hit;
			lit_match_r <= lit_hit;
			if (wr_pit) begin
				pit_interval_r <= hwdata[`WKT_PIT_W-1:0];
				pit_cmp_r <= cnt_r[`WKT_PIT_MSB:0] + hwdata[`WKT_PIT_W-1:0];
			end else if (pit_hit) begin
				pit_cmp_r <= pit_cmp_r + pit_interval_r;
			end
			if (wr_lit)
				lit_cmp_r <= hwdata[`WKT_LIT_W-1:0];
		end
	end

	// External pins pass two flops before any edge logic looks at them.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_r <= {(NSRC-`WKT_SRC_INT_N){1'b0}};
			pin_s2_r <= {(NSRC-`WKT_SRC_INT_N){1'b0}};
			src_prev_r <= {NSRC{1'b0}};
		end else begin
			pin_s1_r <= wake_pin;
			pin_s2_r <= pin_s1_r;
			src_prev_r <= src_lvl;
		end
	end

	assign src_lvl = {pin_s2_r, lit_hit, pit_hit};
	assign clr_mask = (wr_pend_r && wr_addr_r == `WKT_OFS_CLEAR) ?
		hwdata[NSRC-1:0] : {NSRC{1'b0}};

	genvar i;
	generate
		for (i = 0; i < NSRC; i = i + 1) begin : g_src
			assign src_event[i] = (src_lvl[i] & ~src_prev_r[i] & rise_edge_event_enables[i]) |
				(~src_lvl[i] & src_prev_r[i] & fall_edge_event_enables[i]);
			assign flags_nxt[i] = src_event[i] | (wakeup_status_flags[i] & ~clr_mask[i]);
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wakeup_status_flags <= {NSRC{1'b0}};
			rise_edge_event_enables <= {NSRC{1'b0}};
			fall_edge_event_enables <= {NSRC{1'b0}};
			flag_irq_enables <= {NSRC{1'b0}};
			wakeup_req_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			wakeup_status_flags <= flags_nxt;
			if (wr_pend_r && wr_addr_r == `WKT_OFS_RISE_EN)
				rise_edge_event_enables <= hwdata[NSRC-1:0];
			if (wr_pend_r && wr_addr_r == `WKT_OFS_FALL_EN)
				fall_edge_event_enables <= hwdata[NSRC-1:0];
			if (wr_pend_r && wr_addr_r == `WKT_OFS_IRQ_EN)
				flag_irq_enables <= hwdata[NSRC-1:0];
			wakeup_req_r <= lp_mode & (|wakeup_status_flags);
			irq_r <= ~lp_mode & (|(wakeup_status_flags & flag_irq_enables));
		end
	end

endmodule

// >>> pkg/wkt_regs.vh
// Register map, field positions and constants of the wake-up timer and event flag unit.
`ifndef WKT_REGS_VH
`define WKT_REGS_VH

// Register byte offsets, one 32-bit word each.
`define WKT_ADDR_W 6
`define WKT_OFS_STATUS 6'h00
`define WKT_OFS_CLEAR 6'h04
`define WKT_OFS_RISE_EN 6'h08
`define WKT_OFS_FALL_EN 6'h0C
`define WKT_OFS_IRQ_EN 6'h10
`define WKT_OFS_CTRL 6'h14
`define WKT_OFS_PIT_INTERVAL 6'h18
`define WKT_OFS_LIT_CMP 6'h1C
`define WKT_OFS_COUNT 6'h20
`define WKT_OFS_PIT_CMP 6'h24

// Control register fields.
`define WKT_CTRL_RUN 0
`define WKT_CTRL_SEL_LSB 1
`define WKT_CTRL_SEL_MSB 2
`define WKT_CTRL_PRESCALE_BY_512_ENABLE 3
`define WKT_CTRL_DIV32 4
`define WKT_CTRL_PIT_EN 5
`define WKT_CTRL_LIT_EN 6
`define WKT_CTRL_W 7
`define WKT_CTRL_RESET 7'h00

// Counter clock source codes.
`define WKT_SEL_SLOW_INT 2'h0
`define WKT_SEL_SLOW_XTAL 2'h1
`define WKT_SEL_FAST_INT 2'h2
`define WKT_SEL_NONE 2'h3

// Prescaler terminal counts.
`define WKT_DIVA_W 9
`define WKT_DIVA_LAST 9'h1FF
`define WKT_DIVB_W 5
`define WKT_DIVB_LAST 5'h1F

// Counter slices used by the two compare channels.
`define WKT_CNT_W 32
`define WKT_PIT_W 10
`define WKT_PIT_MSB 9
`define WKT_LIT_W 12
`define WKT_LIT_LSB 10
`define WKT_LIT_MSB 21

// Source bit positions of the two internal timers.
`define WKT_SRC_PIT 0
`define WKT_SRC_LIT 1
`define WKT_SRC_INT_N 2

`endif

// >>> tb/wkt_asserts.sv
// Bus and output checks bound to the wake-up timer top.
module wkt_asserts (
	// Clock and reset
	input logic hclk,
	input logic hresetn,
	// Bus
	input logic hsel,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	// Mode and events
	input logic lp_mode,
	input logic wakeup_req_r,
	input logic irq_r,
	input logic pit_match_r,
	input logic lit_match_r
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_take;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	AST_RD_WAIT: assert property (rd_take |=> rd_answer)
		else $error("read wait state wrong");
	AST_READY: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hreadyout)
		else $error("unexpected wait state");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_RDATA_HOLD: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data changed outside a read");
	AST_IRQ_LP: assert property (lp_mode |=> !irq_r)
		else $error("interrupt raised in low power");
	AST_WAKE_RUN: assert property (!lp_mode |=> !wakeup_req_r)
		else $error("wake request outside low power");
	AST_PIT_ONE: assert property (pit_match_r |=> !pit_match_r)
		else $error("periodic match pulse too long");
	AST_LIT_GAP: assert property (lit_match_r |=> !lit_match_r [*8])
		else $error("long match repeated too soon");
endmodule

bind wkt_top wkt_asserts chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .lp_mode, .wakeup_req_r, .irq_r, .pit_match_r,
	.lit_match_r);

// >>> tb/wkt_pmu_model.sv
// Low-power mode controller that sleeps on command and leaves on a wake request.
module wkt_pmu_model (
	// Clock and reset
	input logic hclk,
	input logic hresetn,
	// Bench command and exit latency
	input logic sleep_req,
	input int exit_dly,
	// Device side
	input logic wakeup_req_r,
	output logic lp_mode
);
	timeunit 1ns;
	timeprecision 10ps;
	int cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lp_mode <= 1'b0;
			cnt <= 0;
		end else if (sleep_req) begin
			lp_mode <= 1'b1;
			cnt <= 0;
		end else if (lp_mode && wakeup_req_r) begin
			cnt <= cnt + 1;
			if (cnt >= exit_dly)
				lp_mode <= 1'b0;
		end
	end
endmodule

// >>> tb/wkt_top_tb.sv
// Self-checking bench for the wake-up timer top.
module wkt_top_tb;
	timeunit 1ns;
	timeprecision 10ps;
	logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, irq_s;
	logic [31:0] haddr = 0, hwdata = 0, q, rd_s, c;
	logic [1:0] htrans = 0;
	logic sio = 0, sxo = 0, fio = 0, sleep_req = 0;
	logic [26:0] wake_pin = 0;
	logic [4:0] os;
	wire hreadyout, hresp, wakeup_req_r, irq_r, pit_match_r, lit_match_r, lp_mode;
	wire [31:0] hrdata;
	wire [4:0] obs = {lp_mode, irq_r, wakeup_req_r, lit_match_r, pit_match_r};
	int fail_count = 0, checks_done = 0, n, t;
	logic [31:0] rows [6][3] = '{'{6'h08, -1, 32'h1FFFFFFF}, '{6'h0C, -1, 32'h1FFFFFFF},
		'{6'h10, -1, 32'h1FFFFFFF}, '{6'h1C, -1, 12'hFFF}, '{6'h3C, -1, 0}, '{0, -1, 0}};
	always #2 hclk = ~hclk;
	always #31.25 fio = ~fio;
	always #3906.25 sio = ~sio;
	always #15625 sxo = ~sxo;
	wkt_top dut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.slow_internal_oscillator(sio), .slow_crystal_oscillator(sxo),
		.fast_internal_oscillator(fio), .wake_pin, .lp_mode, .wakeup_req_r, .irq_r,
		.pit_match_r, .lit_match_r);
	wkt_pmu_model pmu (.hclk, .hresetn, .sleep_req, .exit_dly(20), .wakeup_req_r, .lp_mode);
	task automatic chk(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic edge_rdy;
		logic r;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rd_s = hrdata;
			irq_s = irq_r;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		q = rd_s;
	endtask
	task automatic pin(input logic v, input logic [31:0] e);
		wake_pin[0] <= v;
		repeat (6) @(posedge hclk);
		bus(1'b0, 6'h00, 0);
		chk(q, e);
	endtask
	task automatic rate(input logic [31:0] ctl, input int cyc, lo, hi);
		bus(1'b1, 6'h14, ctl);
		bus(1'b0, 6'h20, 0);
		c = q;
		repeat (cyc) @(posedge hclk);
		bus(1'b0, 6'h20, 0);
		chk((q - c) inside {[lo:hi]}, 1);
	endtask
	task automatic await(input int k, lim);
		n = 0;
		do begin
			@(negedge hclk);
			os = obs;
			n++;
		end while (os[k] !== 1'b1 && n < lim);
		@(posedge hclk);
		chk(n < lim, 1);
	endtask
	task give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400us;
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, rows[i][0], rows[i][1]);
			bus(1'b0, rows[i][0], 0);
			chk(q, rows[i][2]);
		end
		$display("test table done");
		bus(1'b1, 6'h10, 0);
		bus(1'b1, 6'h08, 4);
		bus(1'b1, 6'h0C, 0);
		bus(1'b1, 6'h04, -1);
		pin(1'b1, 4);
		chk(irq_s, 0);
		bus(1'b1, 6'h10, 4);
		bus(1'b0, 6'h00, 0);
		chk(irq_s, 1);
		bus(1'b1, 6'h04, 0);
		pin(1'b1, 4);
		bus(1'b1, 6'h04, 4);
		pin(1'b0, 0);
		chk(irq_s, 0);
		bus(1'b1, 6'h08, 0);
		bus(1'b1, 6'h0C, 4);
		pin(1'b1, 0);
		pin(1'b0, 4);
		$display("test pins done");
		rate(6'h07, 1000, 0, 0);
		rate(6'h01, 8000, 3, 5);
		rate(6'h03, 8000, 0, 2);
		rate(6'h15, 5000, 9, 11);
		rate(6'h0D, 16000, 1, 3);
		rate(6'h05, 1000, 62, 66);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 6'h14, 0);
		chk(q, 7'h05);
		bus(1'b0, 6'h20, 0);
		chk((q - c) inside {[62:80]}, 1);
		por_n <= 1'b0;
		@(posedge hclk);
		por_n <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 6'h20, 0);
		chk(q, 0);
		$display("test counter done");
		bus(1'b1, 6'h14, 7'h25);
		bus(1'b1, 6'h18, 10'h010);
		await(0, 1000);
		t = $time;
		await(0, 1000);
		chk(($time - t) inside {[920:1080]}, 1);
		$display("test periodic done");
		bus(1'b1, 6'h14, 7'h45);
		bus(1'b1, 6'h08, 2);
		bus(1'b1, 6'h10, 2);
		bus(1'b0, 6'h20, 0);
		// Aim two long periods ahead so a tick during the write cannot skip the match.
		bus(1'b1, 6'h1C, q[21:10] + 12'h002);
		sleep_req <= 1'b1;
		@(posedge hclk);
		sleep_req <= 1'b0;
		await(1, 36000);
		chk(os[4], 1);
		await(2, 10);
		chk(os[3], 0);
		await(3, 100);
		chk(os[4], 0);
		$display("test wake done");
		give_verdict();
	end
endmodule
